/* sas_regs.svh */
// register offsets, field positions, reset values and timing counts for the converter sequencer
`ifndef SAS_REGS_SVH
`define SAS_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SAS_CTRL0_OFF    12'h000
`define SAS_CTRL1_OFF    12'h004
`define SAS_TCFG_OFF     12'h008
`define SAS_RESH_OFF     12'h00C
`define SAS_RESL_OFF     12'h010
`define SAS_STAT_OFF     12'h014

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SAS_EN_BIT       0
`define SAS_GO_BIT       1
`define SAS_CHS_LSB      2
`define SAS_CHS_MSB      5
`define SAS_PCFG_LSB     0
`define SAS_PCFG_MSB     3
`define SAS_VCFG_LSB     4
`define SAS_VCFG_MSB     5
`define SAS_CS_LSB       0
`define SAS_CS_MSB       2
`define SAS_ACQ_LSB      3
`define SAS_ACQ_MSB      5
`define SAS_FMT_BIT      7
`define SAS_DONE_BIT     0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SAS_CTRL0_RST    8'h00
`define SAS_CTRL1_RST    8'h00
`define SAS_TCFG_RST     8'h00

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define SAS_CONV_TADS    5'd13
`define SAS_WAIT_TCY     2
`define SAS_TCY_CLKS     4
`define SAS_DISCH_CLKS   4'd2

`endif

/* sas_pkg.sv */
// types shared by the converter sequencer
package sas_pkg;
  typedef enum logic [2:0] {
    SAS_IDLE,
    SAS_DISCH,
    SAS_ACQ,
    SAS_DELAY,
    SAS_CONV,
    SAS_WAIT
  } sas_state_e;
endpackage

/* sas_tad_gen.sv */
// conversion bit period tick generator from oscillator divider or rc clock input
`include "sas_regs.svh"
module sas_tad_gen
  import sas_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       run,
  input  wire logic [2:0] clk_sel,
  input  wire logic       rc_tick,
  // tick out
  output logic            tad_tick
);
  logic [6:0] cnt_r;
  logic [6:0] div_w;
  logic       rc_sel_w;
  logic       wrap_w;

  // --------------------------------------------------------------
  // divider decode: bit 2 selects the doubling
  // --------------------------------------------------------------
  assign rc_sel_w = (clk_sel[1:0] == 2'b11);
  assign div_w    = 7'h02 << {clk_sel[1:0], clk_sel[2]};
  assign wrap_w   = (cnt_r == div_w - 7'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 7'h00;
    end else if (!run || wrap_w) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_r + 7'h01;
    end
  end

  assign tad_tick = run && (rc_sel_w ? rc_tick : wrap_w);
endmodule

/* sas_sar.sv */
// successive approximation register, one bit decided per step
module sas_sar
  import sas_pkg::*;
#(
  parameter int WIDTH = 12
)
(
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // control
  input  wire logic             start,
  input  wire logic             step,
  input  wire logic             cmp_hi,
  // trial and result
  output logic [WIDTH-1:0]      trial,
  output logic                  last
);
  logic [WIDTH-1:0] val_r;
  logic [WIDTH-1:0] mask_r;

  assign trial = val_r | mask_r;
  assign last  = mask_r[0];

  // --------------------------------------------------------------
  // keep trial bit when the held input is at or above it
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_r  <= '0;
      mask_r <= '0;
    end else if (start) begin
      val_r  <= '0;
      mask_r <= {1'b1, {(WIDTH-1){1'b0}}};
    end else if (step && mask_r != '0) begin
      val_r  <= cmp_hi ? trial : val_r;
      mask_r <= mask_r >> 1;
    end
  end
endmodule

/* sas_sequencer.sv */
// top of the converter sequencer: apb registers, acquisition and conversion control
//
// Notes on behaviour
// - reset disables converter, aborts any conversion
// - done loads result, clears go, sets flag
// - acquisition field bits 5:3 selects 2-20 periods
// - programmed acquisition then conversion starts automatically
// - manual mode converts on go after discharge and a one instruction delay
// - acquisition field resets to manual zero
// - two instruction cycles wait, then resample
// - no status shows acquisition or conversion phase
// - conversion takes thirteen bit periods
// - clock select encodes divider or rc
// - rc clock keeps converting during sleep
// - sample-and-hold resolved by successive approximation
// - clearing go aborts, result kept
// - manual start delayed by one instruction
// - holding capacitor discharged after go, before acquisition or the manual delay
// - port pins configurable analog or digital
// - reference selects supply rails or pins
// - special trigger sets go only when enabled
//
// The APB interface to the registers and the placing of the registers were decided locally.
`include "sas_regs.svh"
module sas_sequencer
  import sas_pkg::*;
#(
  parameter int RES_W = 12
)
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // system events
  input  wire logic        special_trig,
  input  wire logic        rc_tick,
  input  wire logic        cmp_hi,
  // analog side
  output logic             analog_en,
  output logic             sample_on,
  output logic             discharge_on,
  output logic [3:0]       channel_sel,
  output logic [RES_W-1:0] dac_trial,
  output logic [3:0]       pin_cfg,
  output logic [1:0]       vref_sel,
  output logic             conversion_done_irq_flag
);
  logic [7:0]       ctrl0_r;
  logic [7:0]       ctrl1_r;
  logic [7:0]       tcfg_r;
  logic [RES_W-1:0] res_r;
  logic             go_r;
  sas_state_e       st_r;
  sas_state_e       st_nxt;
  logic [4:0]       tad_cnt_r;
  logic [3:0]       clk_cnt_r;
  logic [31:0]      prdata_nxt;
  logic             tad_tick;
  logic [RES_W-1:0] sar_trial;
  logic             phase_new_r;
  logic [4:0]       conv_ticks_r;

  // --------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------
  wire        acc_w    = psel && penable;
  wire        wr_w     = acc_w && pwrite;
  wire        wr_c0_w  = wr_w && paddr == `SAS_CTRL0_OFF;
  wire        wr_c1_w  = wr_w && paddr == `SAS_CTRL1_OFF;
  wire        wr_tc_w  = wr_w && paddr == `SAS_TCFG_OFF;
  wire        wr_rh_w  = wr_w && paddr == `SAS_RESH_OFF;
  wire        wr_rl_w  = wr_w && paddr == `SAS_RESL_OFF;
  wire        wr_st_w  = wr_w && paddr == `SAS_STAT_OFF;
  wire        mapped_w = paddr == `SAS_CTRL0_OFF || paddr == `SAS_CTRL1_OFF || paddr == `SAS_TCFG_OFF ||
                         paddr == `SAS_RESH_OFF || paddr == `SAS_RESL_OFF || paddr == `SAS_STAT_OFF;
  wire        en_w     = ctrl0_r[`SAS_EN_BIT];
  wire [2:0]  acq_w    = tcfg_r[`SAS_ACQ_MSB:`SAS_ACQ_LSB];
  wire        fmt_w    = tcfg_r[`SAS_FMT_BIT];
  wire        wgo_w    = pwdata[`SAS_GO_BIT];
  wire        busy_w   = st_r != SAS_IDLE && st_r != SAS_WAIT;
  wire        tad_run_w = busy_w && !phase_new_r;
  wire [15:0] res16_w  = fmt_w ? {4'h0, res_r} : {res_r, 4'h0};

  // acquisition length: 0,2,4,6,8,12,16,20 periods
  wire [4:0]  acq_len_w = (acq_w == 3'h5) ? 5'd12 : (acq_w == 3'h6) ? 5'd16 :
                          (acq_w == 3'h7) ? 5'd20 : {1'b0, acq_w, 1'b0};

  // go set by software or by trigger only when enabled
  wire        trig_go_w = special_trig && en_w;
  wire        sw_go_w   = wr_c0_w && wgo_w && en_w && pwdata[`SAS_EN_BIT];
  wire        sw_clr_w  = wr_c0_w && !wgo_w;
  wire        start_w   = (trig_go_w || sw_go_w) && !go_r;
  wire        done_w    = st_r == SAS_CONV && tad_tick && tad_cnt_r == `SAS_CONV_TADS - 5'd1;
  wire        abort_w   = busy_w && (sw_clr_w || !en_w);

  // wait length: two instruction cycles in pclk
  localparam logic [3:0] WAIT_CLKS = 4'(`SAS_WAIT_TCY * `SAS_TCY_CLKS);

  always_comb begin
    unique case (addr_sel(paddr))
      3'd0:    prdata_nxt = {24'h0, ctrl0_r[7:2], go_r, en_w};
      3'd1:    prdata_nxt = {24'h0, ctrl1_r};
      3'd2:    prdata_nxt = {24'h0, tcfg_r};
      3'd3:    prdata_nxt = {24'h0, res16_w[15:8]};
      3'd4:    prdata_nxt = {24'h0, res16_w[7:0]};
      3'd5:    prdata_nxt = {31'h0, conversion_done_irq_flag};
      default: prdata_nxt = 32'h0;
    endcase
  end

  function automatic logic [2:0] addr_sel(input logic [11:0] a);
    addr_sel = (a == `SAS_CTRL0_OFF) ? 3'd0 : (a == `SAS_CTRL1_OFF) ? 3'd1 :
               (a == `SAS_TCFG_OFF) ? 3'd2 : (a == `SAS_RESH_OFF) ? 3'd3 :
               (a == `SAS_RESL_OFF) ? 3'd4 : (a == `SAS_STAT_OFF) ? 3'd5 : 3'd7;
  endfunction

  // --------------------------------------------------------------
  // sequencer state machine
  // --------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      SAS_IDLE:  if (start_w || go_r) st_nxt = SAS_DISCH;
      SAS_DISCH: if (clk_cnt_r == `SAS_DISCH_CLKS - 4'd1)
                   st_nxt = (acq_w == 3'h0) ? SAS_DELAY : SAS_ACQ;
      SAS_ACQ:   if (tad_tick && tad_cnt_r == acq_len_w - 5'd1) st_nxt = SAS_CONV;
      SAS_DELAY: if (clk_cnt_r == 4'(`SAS_TCY_CLKS - 1)) st_nxt = SAS_CONV;
      SAS_CONV:  if (done_w) st_nxt = SAS_WAIT;
      SAS_WAIT:  if (clk_cnt_r == WAIT_CLKS - 4'd1) st_nxt = SAS_IDLE;
      default:   st_nxt = SAS_IDLE;
    endcase
    if (abort_w) st_nxt = SAS_WAIT;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= SAS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // phase counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tad_cnt_r <= 5'd0;
      clk_cnt_r <= 4'd0;
    end else if (st_nxt != st_r) begin
      tad_cnt_r <= 5'd0;
      clk_cnt_r <= 4'd0;
    end else begin
      tad_cnt_r <= tad_tick ? tad_cnt_r + 5'd1 : tad_cnt_r;
      clk_cnt_r <= clk_cnt_r + 4'd1;
    end
  end

  // restart the bit period divider so every phase gets whole periods when the divider, not rc, is selected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_new_r <= 1'b0;
    end else begin
      phase_new_r <= st_nxt != st_r;
    end
  end

  // bit periods seen in the current conversion, for the length check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_ticks_r <= 5'd0;
    end else if (st_r != SAS_CONV) begin
      conv_ticks_r <= 5'd0;
    end else if (tad_tick) begin
      conv_ticks_r <= conv_ticks_r + 5'd1;
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_r <= `SAS_CTRL0_RST;
      ctrl1_r <= `SAS_CTRL1_RST;
      tcfg_r  <= `SAS_TCFG_RST;
    end else begin
      if (wr_c0_w) ctrl0_r <= {2'b00, pwdata[5:2], 1'b0, pwdata[0]};
      if (wr_c1_w) ctrl1_r <= {2'b00, pwdata[5:0]};
      if (wr_tc_w) tcfg_r  <= {pwdata[7], 1'b0, pwdata[5:0]};
    end
  end

  // go flag: set wins over completion clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_r <= 1'b0;
    end else if (start_w) begin
      go_r <= 1'b1;
    end else if (done_w || sw_clr_w || !en_w) begin
      go_r <= 1'b0;
    end
  end

  // result and done flag; set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_r                    <= '0;
      conversion_done_irq_flag <= 1'b0;
    end else begin
      if (done_w && !abort_w) begin
        res_r <= sar_trial;
      end else if (wr_rh_w) begin
        res_r <= fmt_w ? {pwdata[3:0], res_r[7:0]} : {pwdata[7:0], res_r[3:0]};
      end else if (wr_rl_w) begin
        res_r <= fmt_w ? {res_r[11:8], pwdata[7:0]} : {res_r[11:4], pwdata[7:4]};
      end
      if (done_w && !abort_w) begin
        conversion_done_irq_flag <= 1'b1;
      end else if (wr_st_w && pwdata[`SAS_DONE_BIT]) begin
        conversion_done_irq_flag <= 1'b0;
      end
    end
  end

  // apb answer and analog outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata       <= 32'h0;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      analog_en    <= 1'b0;
      sample_on    <= 1'b0;
      discharge_on <= 1'b0;
      channel_sel  <= 4'h0;
      dac_trial    <= '0;
      pin_cfg      <= 4'h0;
      vref_sel     <= 2'h0;
    end else begin
      prdata       <= (psel && !penable && !pwrite) ? prdata_nxt : prdata;
      pready       <= psel && !penable;
      pslverr      <= psel && !penable && !mapped_w;
      analog_en    <= en_w;
      sample_on    <= en_w && (st_nxt == SAS_IDLE || st_nxt == SAS_ACQ);
      discharge_on <= st_nxt == SAS_DISCH;
      channel_sel  <= ctrl0_r[`SAS_CHS_MSB:`SAS_CHS_LSB];
      dac_trial    <= sar_trial;
      pin_cfg      <= ctrl1_r[`SAS_PCFG_MSB:`SAS_PCFG_LSB];
      vref_sel     <= ctrl1_r[`SAS_VCFG_MSB:`SAS_VCFG_LSB];
    end
  end

  // --------------------------------------------------------------
  // submodules
  // --------------------------------------------------------------
  sas_tad_gen u_tad (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (tad_run_w),
    .clk_sel  (tcfg_r[`SAS_CS_MSB:`SAS_CS_LSB]),
    .rc_tick  (rc_tick),
    .tad_tick (tad_tick)
  );

  sas_sar #(.WIDTH(RES_W)) u_sar (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (st_r != SAS_CONV && st_nxt == SAS_CONV),
    .step    (st_r == SAS_CONV && tad_tick && tad_cnt_r < 5'(RES_W)),
    .cmp_hi  (cmp_hi),
    .trial   (sar_trial),
    .last    ()
  );

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  done_clears_go_a: assert property (@(posedge pclk) disable iff (!presetn)
    done_w && !abort_w && !start_w |=> !go_r && conversion_done_irq_flag)
    else $error("go not cleared or flag not set at completion");
  done_loads_res_a: assert property (@(posedge pclk) disable iff (!presetn)
    done_w && !abort_w |=> res_r == $past(sar_trial))
    else $error("result not loaded at completion");
  abort_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
    abort_w && !wr_rh_w && !wr_rl_w |=> $stable(res_r) && st_r == SAS_WAIT)
    else $error("abort changed result or state");
  manual_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == SAS_DELAY && st_nxt == SAS_CONV |-> $past(st_r, 3) == SAS_DELAY && $past(st_r, 4) == SAS_DISCH)
    else $error("manual start delay wrong");
  wait_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_r == SAS_WAIT) |-> (st_r == SAS_WAIT) [*8] ##1 st_r == SAS_IDLE)
    else $error("restart wait not two instruction cycles");
  trig_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    special_trig && !en_w && !go_r |=> !go_r)
    else $error("trigger accepted while disabled");
  disch_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == SAS_IDLE && st_nxt != SAS_IDLE |=> st_r == SAS_DISCH)
    else $error("sample started without discharge");
  conv_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    done_w |-> conv_ticks_r == 5'd12)
    else $error("conversion length not thirteen periods");
  acq_manual_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == SAS_DISCH && acq_w == 3'h0 |-> st_nxt != SAS_ACQ)
    else $error("manual mode entered programmed acquisition");

  cov_done_c:   cover property (@(posedge pclk) disable iff (!presetn) done_w);
  cov_abort_c:  cover property (@(posedge pclk) disable iff (!presetn) abort_w);
  cov_acq_c:    cover property (@(posedge pclk) disable iff (!presetn) st_r == SAS_ACQ && st_nxt == SAS_CONV);
  cov_trig_c:   cover property (@(posedge pclk) disable iff (!presetn) trig_go_w && start_w);
endmodule

/* sas_analog_model.sv */
// stand-in for the analog input, sample-and-hold and comparator
module sas_analog_model (
  // clock
  input  wire logic        pclk,
  // control from sequencer
  input  wire logic        sample_on,
  input  wire logic [11:0] dac_trial,
  // analog input level
  input  wire logic [11:0] level,
  // comparator
  output logic             cmp_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] held_r = 12'h000;
  // hold cap follows the input only while the switch is closed
  always_ff @(posedge pclk) begin
    if (sample_on)
      held_r <= level;
  end
  // ideal comparator against the trial value
  assign cmp_hi = (held_r >= dac_trial);
endmodule

/* testbench.sv */
// self-checking bench for the converter sequencer
`include "sas_regs.svh"
module testbench;
  import sas_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000, level = 12'h000, last_code;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, cmp_hi, analog_en, sample_on, discharge_on, flag;
  logic        special_trig = 1'b0, rc_tick = 1'b0, rc_on = 1'b0;
  logic [3:0]  channel_sel, pin_cfg;
  logic [11:0] dac_trial;
  logic [1:0]  vref_sel;
  int          num_errors = 0, checked = 0;
  int          cs_div [6] = '{2, 4, 8, 16, 32, 64};
  logic [2:0]  cs_code [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};

  always #4 pclk = ~pclk;
  // rc bit period pulse, one cycle in six
  always begin
    repeat (5) @(posedge pclk);
    rc_tick <= rc_on;
    @(posedge pclk);
    rc_tick <= 1'b0;
  end

  sas_sequencer sas_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_trig(special_trig), .rc_tick(rc_tick), .cmp_hi(cmp_hi), .analog_en(analog_en),
    .sample_on(sample_on), .discharge_on(discharge_on), .channel_sel(channel_sel),
    .dac_trial(dac_trial), .pin_cfg(pin_cfg), .vref_sel(vref_sel), .conversion_done_irq_flag(flag));
  sas_analog_model sas_analog_model_inst (.pclk(pclk), .sample_on(sample_on), .dac_trial(dac_trial),
    .level(level), .cmp_hi(cmp_hi));

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    checked++;
    if (g < lo || g > hi) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // one apb transfer, entered and left just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_rng("apb answer", 1, 49, n);
  endtask

  task automatic wait_flag(output int n);
    n = 0;
    while (flag !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // enable, let three bit periods pass, then start and judge one conversion
  task automatic convert(input logic [2:0] cs, input logic [2:0] acq, input int div, input int acqt,
                         input logic [11:0] code);
    int n;
    int lo;
    level = code;
    apb(1'b1, `SAS_TCFG_OFF, 32'h80 | (acq << 3) | cs);
    apb(1'b1, `SAS_CTRL0_OFF, 32'h01);
    repeat (3 * div + 4) @(posedge pclk);
    apb(1'b1, `SAS_CTRL0_OFF, 32'h03);
    wait_flag(n);
    // manual mode adds discharge and one instruction, programmed mode only discharge
    lo = ((acq == 3'h0) ? 8 : 5) + (13 + acqt) * div;
    // rc periods are not aligned to the phase start
    if (cs[1:0] == 2'b11)
      lo = lo - div + 1;
    chk_rng("convert time", lo, 16 + (15 + acqt) * div, n);
    chk("hold after done", 32'h0, sample_on);
    apb(1'b0, `SAS_RESH_OFF, 32'h0);
    chk("result high", {28'h0, code[11:8]}, rd);
    apb(1'b0, `SAS_RESL_OFF, 32'h0);
    chk("result low", {24'h0, code[7:0]}, rd);
    apb(1'b0, `SAS_CTRL0_OFF, 32'h0);
    chk("go cleared", 32'h01, rd);
    chk("resampling", 32'h1, sample_on);
    apb(1'b1, `SAS_STAT_OFF, 32'h01);
    @(posedge pclk);
    chk("flag cleared", 32'h0, flag);
    last_code = code;
  endtask

  task automatic reset_state();
    apb(1'b0, `SAS_CTRL0_OFF, 32'h0);
    chk("ctrl0 reset", 32'h0, rd);
    apb(1'b0, `SAS_CTRL1_OFF, 32'h0);
    chk("ctrl1 reset", 32'h0, rd);
    apb(1'b0, `SAS_TCFG_OFF, 32'h0);
    chk("acq reset", 32'h0, rd);
    chk("enable reset", 32'h0, analog_en);
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped err", 32'h1, err);
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, `SAS_CTRL1_OFF, 32'h2A);
    apb(1'b1, `SAS_CTRL0_OFF, 32'h3C);
    repeat (2) @(posedge pclk);
    chk("channel sel", 32'hF, channel_sel);
    chk("pin cfg", 32'hA, pin_cfg);
    chk("vref sel", 32'h2, vref_sel);
  endtask

  task automatic abort_conv();
    apb(1'b1, `SAS_TCFG_OFF, 32'h86);
    level = 12'h123;
    apb(1'b1, `SAS_CTRL0_OFF, 32'h03);
    repeat (100) @(posedge pclk);
    apb(1'b1, `SAS_CTRL0_OFF, 32'h01);
    repeat (900) @(posedge pclk);
    chk("abort no flag", 32'h0, flag);
    apb(1'b0, `SAS_RESL_OFF, 32'h0);
    chk("abort result kept", {24'h0, last_code[7:0]}, rd);
  endtask

  task automatic trig_conv();
    int n;
    apb(1'b1, `SAS_CTRL0_OFF, 32'h00);
    special_trig <= 1'b1;
    @(posedge pclk);
    special_trig <= 1'b0;
    apb(1'b0, `SAS_CTRL0_OFF, 32'h0);
    chk("trig ignored", 32'h0, rd);
    apb(1'b1, `SAS_TCFG_OFF, 32'h80);
    apb(1'b1, `SAS_CTRL0_OFF, 32'h01);
    repeat (10) @(posedge pclk);
    special_trig <= 1'b1;
    @(posedge pclk);
    special_trig <= 1'b0;
    @(posedge pclk);
    chk("discharge first", 32'h1, discharge_on);
    wait_flag(n);
    chk("trig converts", 32'h1, flag);
    apb(1'b1, `SAS_STAT_OFF, 32'h01);
  endtask

  task automatic mid_reset();
    apb(1'b1, `SAS_CTRL0_OFF, 32'h03);
    repeat (10) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset disables", 32'h0, analog_en);
    presetn <= 1'b1;
    apb(1'b0, `SAS_CTRL0_OFF, 32'h0);
    chk("reset aborts", 32'h0, rd);
  endtask

  initial begin
    #(8 * 30000);
    num_errors++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    reset_state();
    for (int i = 0; i < 6; i++)
      convert(cs_code[i], 3'h0, cs_div[i], 0, 12'hA5C ^ (i << 4));
    convert(3'h4, 3'h7, 4, 20, 12'h3F1);
    rc_on = 1'b1;
    convert(3'h3, 3'h0, 6, 0, 12'h7FF);
    rc_on = 1'b0;
    abort_conv();
    trig_conv();
    mid_reset();
    test_done();
  end
endmodule
